/* File: hdl/wbo_top.sv */
`timescale 1ns/100ps
`include "wbo_defines.svh"
// Core-side store posting and bus write ordering. Posted writes enter a
// buffer FIFO (two slots shared by both pipes, four in extended mode); the
// bus side pops one cycle at a time with bus_ready_ack as completion.
module wbo_top #(
  parameter int FIFO_DEPTH = `WBO_FIFO_DEPTH,
  parameter bit EXTENDED = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic u_wr_valid,
  input wire wbo_pkg::wbo_qw_t u_wr,
  input wire logic v_wr_valid,
  input wire wbo_pkg::wbo_qw_t v_wr,
  input wire logic u_first_issue,
  output logic wr_post_ready,
  input wire logic io_wr_valid,
  input wire wbo_pkg::wbo_qw_t io_wr,
  input wire logic rd_req,
  input wire logic io_rd_req,
  input wire logic [31:0] rd_addr,
  output logic rd_grant,
  input wire logic ser_req,
  input wire logic port_wr_done_req,
  output logic fetch_ok,
  output logic prefetch_flush,
  input wire logic em_write_req,
  output logic em_write_ok,
  input wire logic ext_snoop_hit,
  input wire logic int_snoop_hit,
  input wire wbo_pkg::wbo_line_t snoop_line,
  input wire logic fill_start,
  input wire logic fill_code,
  input wire logic fill_victim_mod,
  input wire wbo_pkg::wbo_line_t victim_line,
  input wire logic fill_data_valid,
  input wire logic [63:0] fill_data,
  output logic crit_valid,
  output logic [63:0] crit_data,
  output logic dfill_done,
  output logic cfill_done,
  output wbo_pkg::wbo_line_t fill_line,
  output logic bus_wr_valid,
  output logic bus_wr_line,
  output logic bus_wr_io,
  output wbo_pkg::wbo_line_t bus_wr,
  output logic bus_rd_valid,
  output logic [31:0] bus_rd_addr,
  input wire logic bus_ready_ack_n,
  input wire logic bus_backoff_n,
  input wire logic external_store_drained_n
);
  localparam int QW = `WBO_QW_W + `WBO_ADDR_W;
  localparam int LQ = `WBO_LINE_QW;
  // Pin synchronisers
  logic [1:0] ack_s_ff, bus_backoff_s_ff, esd_s_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s_ff <= 2'h0;
      bus_backoff_s_ff <= 2'h0;
      esd_s_ff <= 2'h0;
    end else if (ce) begin
      ack_s_ff <= {ack_s_ff[0], ~bus_ready_ack_n};
      bus_backoff_s_ff <= {bus_backoff_s_ff[0], ~bus_backoff_n};
      esd_s_ff <= {esd_s_ff[0], ~external_store_drained_n};
    end
  end
  logic ack, bus_backoff, esd;
  assign ack = ack_s_ff[1];
  assign bus_backoff = bus_backoff_s_ff[1];
  assign esd = esd_s_ff[1];

  // Posting stage: same-clock pair is split, first-issue pipe goes first
  logic pend_ff;
  wbo_pkg::wbo_qw_t pend_q_ff;
  logic in_valid, in_ready;
  wbo_pkg::wbo_qw_t in_data;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fcount;
  logic limit_ok;
  logic [$clog2(FIFO_DEPTH+1)-1:0] cap;
  assign cap = EXTENDED ? ($clog2(FIFO_DEPTH+1))'(`WBO_EXT_BUFS)
                        : ($clog2(FIFO_DEPTH+1))'(`WBO_BASE_BUFS); // see R1 R4
  assign limit_ok = (fcount < cap);
  always_comb begin
    in_valid = 1'b0;
    in_data = u_wr;
    if (pend_ff) begin
      in_valid = 1'b1;
      in_data = pend_q_ff;
    end else if (wr_post_ready) begin
      // New writes only when promised, so a held request is taken once
      if (u_wr_valid && v_wr_valid) begin
        in_valid = 1'b1;
        in_data = u_first_issue ? u_wr : v_wr; // see R19
      end else if (u_wr_valid) begin
        in_valid = 1'b1;
      end else if (v_wr_valid) begin
        in_valid = 1'b1;
        in_data = v_wr;
      end
    end
  end
  logic push_ok;
  assign push_ok = in_valid && in_ready && limit_ok;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= 1'b0;
      pend_q_ff <= '0;
    end else if (ce) begin
      if (pend_ff && push_ok) begin
        pend_ff <= 1'b0;
      end else if (!pend_ff && push_ok && u_wr_valid && v_wr_valid) begin
        pend_ff <= 1'b1; // see R1
        pend_q_ff <= u_first_issue ? v_wr : u_wr;
      end
    end
  end
  logic fo_valid, fo_ready;
  logic [QW-1:0] fo_data;
  // Ready is a promise for the next edge: it looks ahead at the slot the
  // split pair still holds and at this edge's push and pop, so a write
  // that the core keeps raised is never posted twice.
  logic nxt_pend;
  logic [$clog2(FIFO_DEPTH+1)-1:0] nxt_fcount;
  always_comb begin
    nxt_pend = push_ok && u_wr_valid && v_wr_valid;
    if (pend_ff) begin
      nxt_pend = !push_ok;
    end
    nxt_fcount = fcount;
    if (push_ok) begin
      nxt_fcount = nxt_fcount + 1'b1;
    end
    if (fo_valid && fo_ready) begin
      nxt_fcount = nxt_fcount - 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_post_ready <= 1'b0;
    end else if (ce) begin
      wr_post_ready <= !nxt_pend && (nxt_fcount < cap); // see R1 R4
    end
  end
  wbo_fifo #(.WIDTH(QW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(in_valid && limit_ok),
    .in_ready(in_ready),
    .in_data(in_data),
    .out_valid(fo_valid),
    .out_ready(fo_ready),
    .out_data(fo_data),
    .count(fcount)
  );

  // Writeback buffers, one line each
  logic [2:0] wb_full_ff;
  wbo_pkg::wbo_line_t wb_line_ff [3];
  // Linefill buffers: index 0 data, 1 code
  logic [1:0] fill_act_ff;
  logic [1:0] fill_cnt_ff [2];
  logic [63:0] fill_buf_ff [2][LQ];
  logic [31:0] fill_addr_ff [2];
  logic victim_pend_ff;
  wbo_pkg::wbo_line_t victim_ff;
  logic fill_sel_ff;

  // Bus engine
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_WR = 4'h2,
    S_RD = 4'h4,
    S_IO = 4'h8
  } wbo_bus_st_t;
  wbo_bus_st_t st_ff;
  wbo_pkg::wbo_wb_src_t cur_src_ff;
  logic posted_empty;
  assign posted_empty = !fo_valid && !pend_ff;
  logic wb_any;
  assign wb_any = |wb_full_ff;
  // Reads hold until posted writes drain; a pending writeback under
  // backoff may still go first, which is the only permitted pass.
  logic rd_allowed;
  assign rd_allowed = posted_empty || (bus_backoff && wb_any); // see R3 R7 R12
  function automatic wbo_pkg::wbo_wb_src_t pick(input logic [2:0] f);
    if (f[0]) return wbo_pkg::WBO_SRC_EXT; // see R18
    else if (f[1]) return wbo_pkg::WBO_SRC_INT;
    else if (f[2]) return wbo_pkg::WBO_SRC_REP;
    else return wbo_pkg::WBO_SRC_NONE;
  endfunction
  assign fo_ready = (st_ff == S_IDLE) && !wb_any && !io_wr_valid;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= S_IDLE;
      cur_src_ff <= wbo_pkg::WBO_SRC_NONE;
      bus_wr_valid <= 1'b0;
      bus_wr_line <= 1'b0;
      bus_wr_io <= 1'b0;
      bus_wr <= '0;
      bus_rd_valid <= 1'b0;
      bus_rd_addr <= '0;
      rd_grant <= 1'b0;
    end else if (ce) begin
      rd_grant <= 1'b0;
      unique case (st_ff)
        S_IDLE: begin
          if (wb_any) begin
            st_ff <= S_WR;
            cur_src_ff <= pick(wb_full_ff);
            bus_wr_valid <= 1'b1;
            bus_wr_line <= 1'b1;
            bus_wr_io <= 1'b0;
            bus_wr <= wb_line_ff[pick(wb_full_ff) - 2'h1];
          end else if (io_wr_valid) begin
            st_ff <= S_IO; // see R6
            bus_wr_valid <= 1'b1;
            bus_wr_line <= 1'b0;
            bus_wr_io <= 1'b1;
            bus_wr <= {io_wr.addr, 192'h0, io_wr.data};
          end else if (fo_valid) begin
            st_ff <= S_WR; // see R2 R4
            cur_src_ff <= wbo_pkg::WBO_SRC_NONE;
            bus_wr_valid <= 1'b1;
            bus_wr_line <= 1'b0;
            bus_wr_io <= 1'b0;
            bus_wr <= {fo_data[QW-1:64], 192'h0, fo_data[63:0]};
          end else if ((rd_req || io_rd_req) && rd_allowed) begin
            st_ff <= S_RD;
            bus_rd_valid <= 1'b1;
            bus_rd_addr <= rd_addr;
          end
        end
        S_WR, S_IO: begin
          if (ack) begin
            st_ff <= S_IDLE;
            bus_wr_valid <= 1'b0;
            bus_wr_io <= 1'b0;
          end
        end
        S_RD: begin
          if (ack) begin
            st_ff <= S_IDLE;
            bus_rd_valid <= 1'b0;
            rd_grant <= 1'b1; // see R12
          end
        end
      endcase
    end
  end

  // Writeback buffer fill and release
  logic fill_end;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_full_ff <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        wb_line_ff[i] <= '0;
      end
    end else if (ce) begin
      if (st_ff == S_WR && ack && cur_src_ff != wbo_pkg::WBO_SRC_NONE) begin
        wb_full_ff[cur_src_ff - 2'h1] <= 1'b0;
      end
      if (ext_snoop_hit) begin
        wb_full_ff[0] <= 1'b1; // see R16 R17
        wb_line_ff[0] <= snoop_line;
      end
      if (int_snoop_hit) begin
        wb_full_ff[1] <= 1'b1; // see R17
        wb_line_ff[1] <= snoop_line;
      end
      if (fill_end && victim_pend_ff) begin
        wb_full_ff[2] <= 1'b1; // see R22
        wb_line_ff[2] <= victim_ff;
      end
    end
  end

  // Linefill: first quadword is the critical one, forwarded at once
  assign fill_end = fill_data_valid &&
      fill_cnt_ff[fill_sel_ff] == 2'(LQ-1) && fill_act_ff[fill_sel_ff];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_act_ff <= 2'h0;
      fill_sel_ff <= 1'b0;
      victim_pend_ff <= 1'b0;
      victim_ff <= '0;
      crit_valid <= 1'b0;
      crit_data <= '0;
      dfill_done <= 1'b0;
      cfill_done <= 1'b0;
      fill_line <= '0;
      for (int b = 0; b < 2; b++) begin
        fill_cnt_ff[b] <= 2'h0;
        fill_addr_ff[b] <= '0;
        for (int q = 0; q < LQ; q++) begin
          fill_buf_ff[b][q] <= '0;
        end
      end
    end else if (ce) begin
      crit_valid <= 1'b0;
      dfill_done <= 1'b0;
      cfill_done <= 1'b0;
      if (fill_start) begin
        fill_sel_ff <= fill_code;
        fill_act_ff[fill_code] <= 1'b1;
        fill_cnt_ff[fill_code] <= 2'h0;
        fill_addr_ff[fill_code] <= rd_addr;
        if (!fill_code && fill_victim_mod) begin
          victim_pend_ff <= 1'b1; // see R22
          victim_ff <= victim_line;
        end
      end else if (fill_data_valid && fill_act_ff[fill_sel_ff]) begin
        fill_buf_ff[fill_sel_ff][fill_cnt_ff[fill_sel_ff]] <= fill_data;
        fill_cnt_ff[fill_sel_ff] <= fill_cnt_ff[fill_sel_ff] + 2'h1;
        if (fill_cnt_ff[fill_sel_ff] == 2'h0) begin
          crit_valid <= 1'b1; // see R21
          crit_data <= fill_data;
        end
        if (fill_end) begin
          fill_act_ff[fill_sel_ff] <= 1'b0; // see R20
          fill_line <= {fill_addr_ff[fill_sel_ff], fill_data,
                        fill_buf_ff[fill_sel_ff][2],
                        fill_buf_ff[fill_sel_ff][1],
                        fill_buf_ff[fill_sel_ff][0]};
          dfill_done <= !fill_sel_ff;
          cfill_done <= fill_sel_ff;
          if (!fill_sel_ff) begin
            victim_pend_ff <= 1'b0;
          end
        end
      end
    end
  end

  // Serialization and port-write completion; never touches the cache
  // writeback buffers, so no modified lines are pushed out.
  logic ser_act_ff, pw_act_ff;
  logic [1:0] ser_cnt_ff;
  logic drained;
  assign drained = posted_empty && st_ff == S_IDLE && !io_wr_valid;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_act_ff <= 1'b0;
      pw_act_ff <= 1'b0;
      ser_cnt_ff <= 2'h0;
      fetch_ok <= 1'b0;
      prefetch_flush <= 1'b0;
      em_write_ok <= 1'b0;
    end else if (ce) begin
      prefetch_flush <= 1'b0;
      if (ser_req) begin
        ser_act_ff <= 1'b1;
        ser_cnt_ff <= EXTENDED ? 2'(`WBO_SER_EXTRA) : 2'h0; // see R15
        prefetch_flush <= 1'b1; // see R10 R11
      end else if (ser_act_ff && drained && esd) begin
        if (ser_cnt_ff != 2'h0) begin
          ser_cnt_ff <= ser_cnt_ff - 2'h1;
        end else begin
          ser_act_ff <= 1'b0; // see R9
        end
      end
      if (port_wr_done_req) begin
        pw_act_ff <= 1'b1; // see R14
      end else if (pw_act_ff && drained && esd) begin
        pw_act_ff <= 1'b0;
      end
      fetch_ok <= !ser_act_ff && !ser_req && !pw_act_ff && !port_wr_done_req;
      em_write_ok <= em_write_req && posted_empty && esd &&
                     !(st_ff == S_WR || st_ff == S_IO); // see R5
    end
  end
endmodule

/* File: hdl/wbo_defines.svh */
// Contract
// R1: Two quadword posted-write buffers, one per pipe, loadable in one clock. Code: one shared two-entry FIFO plus a hold slot for a split pair.
// R2: Posted writes leave on the bus in core generation order.
// R3: Miss reads wait for posted writes, unless backoff with writeback pending.
// R4: Extended variant: four shared buffers, FIFO drain, reads never bypass.
// R5: Block E/M cache writes while buffers busy, bus write, or drain low.
// R6: Only memory writes are posted; I/O writes go straight to bus.
// R7: Drain all write buffers before a port read; reads never pass writes.
// R8: System holds changed inputs three clocks before bus ready ack.
// R9: Serializing drains stores, then waits for store-drained before fetch.
// R10: Every serializing operation flushes the prefetch queue.
// R11: Serializing never triggers writeback of modified cache lines.
// R12: I/O reads wait for internal stores; store-drained not sampled in reads.
// R13: System completes external stores before acking an I/O read.
// R14: Port writes keep prefetching; next instruction waits drain, input, write.
// R15: Extended variant serialization takes one extra clock.
// R16: Three one-entry writeback buffers, each one 32-byte line.
// R17: Writeback buffers: replacement, external snoop, internal snoop hits.
// R18: Bus write priority: ext snoop, int snoop, replacement, posted writes.
// R19: Older write buffer first; same clock gives the first-issue pipe first.
// R20: Data and code linefill buffers commit only once the line is complete.
// R21: Needed item requested first and forwarded to core on return.
// R22: Displaced modified line moves to replacement buffer at fill completion.
`ifndef WBO_DEFINES_SVH
`define WBO_DEFINES_SVH
`define WBO_QW_W 64
`define WBO_ADDR_W 32
`define WBO_LINE_QW 4
`define WBO_FIFO_DEPTH 16
`define WBO_BASE_BUFS 2
`define WBO_EXT_BUFS 4
`define WBO_SER_EXTRA 1
`endif

/* File: hdl/wbo_pkg.sv */
package wbo_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [63:0] data;
  } wbo_qw_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [255:0] line;
  } wbo_line_t;
  typedef enum logic [1:0] {
    WBO_SRC_NONE = 2'h0,
    WBO_SRC_EXT = 2'h1,
    WBO_SRC_INT = 2'h2,
    WBO_SRC_REP = 2'h3
  } wbo_wb_src_t;
endpackage

/* File: hdl/wbo_fifo.sv */
`timescale 1ns/100ps
module wbo_fifo #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;
  assign in_ready = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rp_ff];
  assign count = cnt_ff;
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end
endmodule

/* File: sim/wbo_top_props.sv */
`timescale 1ns/100ps
module wbo_top_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ser_req,
  input wire logic prefetch_flush,
  input wire logic fetch_ok,
  input wire logic em_write_ok,
  input wire logic bus_wr_valid,
  input wire wbo_pkg::wbo_line_t bus_wr,
  input wire logic bus_rd_valid,
  input wire logic bus_ready_ack_n,
  input wire logic external_store_drained_n,
  input wire logic fill_start,
  input wire logic fill_data_valid,
  input wire logic [63:0] fill_data,
  input wire logic crit_valid,
  input wire logic [63:0] crit_data,
  input wire logic dfill_done,
  input wire logic cfill_done
);
  logic first_ff;
  logic [63:0] q0_ff;
  logic [2:0] qn_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_ff <= 1'b0;
      q0_ff <= 64'h0;
    end else if (fill_start) begin
      first_ff <= 1'b1;
    end else if (fill_data_valid && first_ff) begin
      first_ff <= 1'b0;
      q0_ff <= fill_data;
    end
  end
  // Saturates so a stray extra beat cannot wrap back to a legal count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qn_ff <= 3'h0;
    end else if (fill_start) begin
      qn_ff <= 3'h0;
    end else if (fill_data_valid && qn_ff != 3'h4) begin
      qn_ff <= qn_ff + 3'h1;
    end
  end
  property p_em_block;
    external_store_drained_n [*4] |-> !em_write_ok;
  endproperty
  a_em_block: assert property (p_em_block)
    else $error("em write allowed while drain pending");
  property p_ser_wait;
    external_store_drained_n [*3] ##0 ser_req
      ##1 external_store_drained_n [*4] |-> !fetch_ok;
  endproperty
  a_ser_wait: assert property (p_ser_wait)
    else $error("fetch allowed before stores drained");
  property p_flush;
    ser_req |-> ##[1:4] prefetch_flush;
  endproperty
  a_flush: assert property (p_flush)
    else $error("prefetch queue not flushed");
  property p_rd_excl;
    bus_rd_valid |-> !bus_wr_valid;
  endproperty
  a_rd_excl: assert property (p_rd_excl)
    else $error("read and write on bus together");
  property p_wr_stand;
    $rose(bus_wr_valid) ##0 bus_ready_ack_n [*3]
      |-> bus_wr_valid && $stable(bus_wr);
  endproperty
  a_wr_stand: assert property (p_wr_stand)
    else $error("bus write changed before ack");
  property p_wr_drop;
    bus_wr_valid && !bus_ready_ack_n |-> ##[2:4] !bus_wr_valid;
  endproperty
  a_wr_drop: assert property (p_wr_drop)
    else $error("bus write held after ack");
  property p_crit;
    fill_data_valid && first_ff |=> ##[0:1] crit_valid
      && crit_data == q0_ff;
  endproperty
  a_crit: assert property (p_crit)
    else $error("critical item not forwarded");
  property p_fill_whole;
    dfill_done || cfill_done |-> qn_ff == 3'h4;
  endproperty
  a_fill_whole: assert property (p_fill_whole)
    else $error("fill completed before whole line");
  c_fetch: cover property ($rose(fetch_ok));
  c_fill: cover property (dfill_done);
  c_read: cover property (bus_rd_valid);
endmodule

bind wbo_top wbo_top_props ck_u (.*);

/* File: sim/wbo_bus_model.sv */
`timescale 1ns/100ps
module wbo_bus_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] wait_cyc,
  input wire logic ext_pending,
  input wire logic bus_wr_valid,
  input wire logic bus_rd_valid,
  output logic bus_ready_ack_n,
  output logic bus_backoff_n,
  output logic external_store_drained_n
);
  logic [3:0] cnt_ff;
  logic done_ff;
  logic req;
  logic go;
  assign req = bus_wr_valid || bus_rd_valid;
  // Reads are not acked while a store is still pending outside
  assign go = (bus_wr_valid || bus_rd_valid && !ext_pending) && !done_ff
    && cnt_ff >= wait_cyc;
  assign bus_backoff_n = 1'b1;
  assign external_store_drained_n = ext_pending;
  // One ack per request; done_ff keeps a held request from a second ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
      done_ff <= 1'b0;
      bus_ready_ack_n <= 1'b1;
    end else begin
      bus_ready_ack_n <= !go;
      done_ff <= (done_ff || go) && req;
      cnt_ff <= (go || !req) ? 4'h0 : cnt_ff + 4'h1;
    end
  end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n, ce, u_wr_valid, v_wr_valid, u_first_issue, io_wr_valid;
  logic rd_req, io_rd_req, ser_req, port_wr_done_req, em_write_req;
  logic ext_snoop_hit, int_snoop_hit, fill_start, fill_code;
  logic fill_victim_mod, fill_data_valid, ext_pending;
  logic [3:0] wait_cyc;
  logic [31:0] rd_addr, bus_rd_addr;
  logic [63:0] fill_data, crit_data;
  wbo_pkg::wbo_qw_t u_wr, v_wr, io_wr;
  wbo_pkg::wbo_line_t snoop_line, victim_line, fill_line, bus_wr;
  logic wr_post_ready, rd_grant, fetch_ok, prefetch_flush, em_write_ok;
  logic crit_valid, dfill_done, cfill_done, bus_wr_valid, bus_wr_line;
  logic bus_wr_io, bus_rd_valid;
  logic bus_ready_ack_n, bus_backoff_n, external_store_drained_n;
  logic [33:0] seen_q[$];
  int n_errors = 0;
  int checked = 0;
  wbo_top dut_u (.*);
  wbo_bus_model bus_u (.*);
  always #5 clk = ~clk;
  // Records each write as {line, io, address} at its ack edge
  always @(posedge clk) begin
    if (bus_wr_valid && !bus_ready_ack_n) begin
      seen_q.push_back({bus_wr_line, bus_wr_io, bus_wr.addr});
    end
  end
  task automatic final_report;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk_val(input string n, input logic [287:0] e,
      input logic [287:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic guard(input int i);
    if (i > 500) begin
      n_errors++;
      $display("unexpected timeout: expected progress seen none");
      final_report;
    end
  endtask
  task automatic seen(input logic [33:0] e);
    for (int i = 0; seen_q.size() == 0; i++) begin
      guard(i);
      @(negedge clk);
    end
    chk_val("bus write", 288'(e), 288'(seen_q.pop_front()));
  endtask
  task automatic hold;
    for (int i = 0; !wr_post_ready; i++) begin
      guard(i);
      @(negedge clk);
    end
    @(negedge clk);
    {u_wr_valid, v_wr_valid} = 2'h0;
  endtask
  task automatic pair(input logic uf, input logic [31:0] ua, va);
    u_first_issue = uf;
    u_wr = {ua, ua, ua};
    v_wr = {va, va, va};
    {u_wr_valid, v_wr_valid} = 2'h3;
    hold;
  endtask
  task automatic post(input logic [31:0] a);
    u_wr = {a, a, a};
    u_wr_valid = 1'b1;
    hold;
  endtask
  task automatic wait_wr(input logic [31:0] a);
    for (int i = 0; !(bus_wr_valid && bus_wr.addr == a); i++) begin
      guard(i);
      @(negedge clk);
    end
  endtask
  task automatic s_order;
    wait_cyc = 4'h6;
    pair(1'b0, 32'h10, 32'h20);
    pair(1'b1, 32'h30, 32'h40);
    chk_bit("post ready at cap", 1'b0, wr_post_ready);
    seen(34'h20);
    seen(34'h10);
    seen(34'h30);
    seen(34'h40);
  endtask
  task automatic s_prio;
    pair(1'b1, 32'h50, 32'h60);
    wait_wr(32'h50);
    snoop_line = {32'h70, 256'h0};
    int_snoop_hit = 1'b1;
    @(negedge clk);
    snoop_line = {32'h80, 256'h0};
    {int_snoop_hit, ext_snoop_hit} = 2'h1;
    @(negedge clk);
    ext_snoop_hit = 1'b0;
    seen(34'h50);
    seen(34'h2_0000_0080);
    seen(34'h2_0000_0070);
    seen(34'h60);
  endtask
  task automatic s_io;
    wait_cyc = 4'h3;
    io_wr = {32'ha0, 64'h5};
    io_wr_valid = 1'b1;
    for (int i = 0; !(bus_wr_io && !bus_ready_ack_n); i++) begin
      guard(i);
      @(negedge clk);
    end
    @(negedge clk);
    io_wr_valid = 1'b0;
    post(32'h90);
    seen(34'h1_0000_00a0);
    seen(34'h90);
  endtask
  task automatic s_read(input logic io);
    wait_cyc = 4'h6;
    post(32'hb0);
    rd_addr = 32'hc0;
    {rd_req, io_rd_req} = {!io, io};
    for (int i = 0; !bus_rd_valid; i++) begin
      guard(i);
      @(negedge clk);
    end
    chk_val("writes ahead", 288'(1), 288'(seen_q.size()));
    chk_val("read address", 288'(32'hc0), 288'(bus_rd_addr));
    for (int i = 0; !rd_grant; i++) begin
      guard(i);
      @(negedge clk);
    end
    {rd_req, io_rd_req} = 2'h0;
    seen(34'hb0);
  endtask
  task automatic s_em;
    em_write_req = 1'b1;
    ext_pending = 1'b1;
    repeat (6) @(negedge clk);
    chk_bit("em ok pending", 1'b0, em_write_ok);
    ext_pending = 1'b0;
    repeat (6) @(negedge clk);
    chk_bit("em ok idle", 1'b1, em_write_ok);
    post(32'hf0);
    wait_wr(32'hf0);
    chk_bit("em ok writing", 1'b0, em_write_ok);
    seen(34'hf0);
  endtask
  task automatic s_ser(input logic pw);
    logic fl;
    fl = 1'b0;
    ext_pending = 1'b1;
    repeat (4) @(negedge clk);
    {ser_req, port_wr_done_req} = {!pw, pw};
    @(negedge clk);
    {ser_req, port_wr_done_req} = 2'h0;
    repeat (8) begin
      fl = fl | prefetch_flush;
      @(negedge clk);
    end
    chk_bit("prefetch flush", !pw, fl);
    chk_bit("fetch ok", 1'b0, fetch_ok);
    chk_bit("serial writeback", 1'b0, bus_wr_valid);
    ext_pending = 1'b0;
    for (int i = 0; !fetch_ok; i++) begin
      guard(i);
      @(negedge clk);
    end
  endtask
  task automatic s_fill(input logic code);
    logic [255:0] ln;
    ln = 256'h0;
    rd_addr = 32'he0;
    fill_code = code;
    victim_line = {32'hd0, 256'h0};
    {fill_start, fill_victim_mod} = 2'h3;
    @(negedge clk);
    fill_start = 1'b0;
    for (int i = 1; i < 5; i++) begin
      fill_data_valid = 1'b1;
      fill_data = {8{8'(i)}};
      ln = {fill_data, ln[255:64]};
      @(negedge clk);
      if (i == 1) begin
        chk_bit("critical valid", 1'b1, crit_valid);
        chk_val("critical data", 288'(ln[255:192]), 288'(crit_data));
        chk_bit("victim held", 1'b0, bus_wr_valid);
      end
    end
    fill_data_valid = 1'b0;
    for (int i = 0; !(code ? cfill_done : dfill_done); i++) begin
      guard(i);
      @(negedge clk);
    end
    chk_val("fill line", {32'he0, ln}, fill_line);
    chk_bit("other fill done", 1'b0, code ? dfill_done : cfill_done);
    if (!code) begin
      seen(34'h2_0000_00d0);
    end
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wait_cyc = 4'h0;
    {u_wr_valid, v_wr_valid, u_first_issue, io_wr_valid, rd_req} = '0;
    {io_rd_req, ser_req, port_wr_done_req, em_write_req} = '0;
    {ext_snoop_hit, int_snoop_hit, fill_start, fill_code} = '0;
    {fill_victim_mod, fill_data_valid, ext_pending} = '0;
    {rd_addr, fill_data, u_wr, v_wr, io_wr, snoop_line} = '0;
    victim_line = '0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    s_order;
    s_prio;
    s_io;
    s_read(1'b0);
    s_read(1'b1);
    s_em;
    s_ser(1'b0);
    s_ser(1'b1);
    s_fill(1'b1);
    s_fill(1'b0);
    final_report;
  end
endmodule
